// [shared/eepc_pkg.sv]
// Overview of operation
// [R01] 512-byte array at 0x0800 to 0x09ff
// [R02] reset copies nonvolatile config and divider
// [R03] timing uses divided reference tick
// [R04] software loads divider before any operation
// [R05] security blocks changes to 0x08f0-0x08ff
// [R06] security blocks config byte, block, bulk
// [R07] four 128-byte blocks with protect bits
// [R08] protect bits apply on reset or config read
// [R09] divider security locks divider copies forever
// [R10] erased reads 0xff; program clears bits only
// [R11] erase sets bits: byte up to array
// [R12] software never reprograms a zero bit
// [R13] auto mode timer ends cycle, clears enable
// [R14] software follows latch, write, enable order
// [R15] auto mode: poll enable, then drop latch
// [R16] latch captures only valid array writes
// [R17] later writes replace; reads retarget address
// [R18] enable needs latch and captured valid address
// [R19] no array reads while enable set
// [R20] clearing enable and latch clears enable only
// [R21] auto timer ends before nominal time
// [R22] protected bytes stay unchanged
// [R23] mode bits pick program or erase kind
// [R24] latch holds while enable; reset clears controls
// [R25] power-down disables the array
// [R26] divider counts reference cycles, ticks per wrap
// [R27] refused operation raises no high voltage
`default_nettype none
package eepc_pkg;
  localparam logic [15:0] ARR_BASE  = 16'h0800;
  localparam logic [15:0] ARR_LAST  = 16'h09ff;
  localparam logic [15:0] SEC_FIRST = 16'h08f0;
  localparam logic [15:0] SEC_LAST  = 16'h08ff;
  // nonvolatile option bytes sit outside the array
  localparam logic [15:0] NVCFG_ADDR  = 16'hfe10;
  localparam logic [15:0] NVDIVH_ADDR = 16'hfe11;
  localparam logic [15:0] NVDIVL_ADDR = 16'hfe12;
  localparam int          ARR_BYTES   = 512;
  localparam int          BLK_LSB     = 7;
  localparam int          BLK_MSB     = 8;
  localparam int          IDX_MSB     = 8;
  localparam int          DIV_SEC_BIT = 15;
  localparam logic [7:0]  ERASED      = 8'hff;
  // durations in timebase ticks
  localparam logic [9:0]  AUTO_TICKS  = 10'h0fa;
  localparam logic [9:0]  NOM_TICKS   = 10'h11e;
  localparam logic [9:0]  TICKS_MAX   = 10'h3ff;

  typedef enum logic [1:0] {
    OP_BYTE_PGM  = 2'b00,
    OP_BYTE_ERS  = 2'b01,
    OP_BLOCK_ERS = 2'b10,
    OP_BULK_ERS  = 2'b11
  } eepc_op_t;

  typedef struct packed {
    logic spare;
    logic array_power_down;
    logic op_select_hi;
    logic op_select_lo;
    logic bus_latch_bit;
    logic auto_mode;
    logic hv_enable_bit;
  } eepc_ctl_t;

  typedef struct packed {
    logic [2:0] spare;
    logic       region_security_bit;
    logic [3:0] block_protect_bits;
  } eepc_acr_t;

  localparam eepc_ctl_t CTL_RESET = '0;
endpackage : eepc_pkg
`default_nettype wire

// [tb/eepc_cpu_model.sv]
`default_nettype none
module eepc_cpu_model
  import eepc_pkg::*;
(
  input  wire logic       mclk,            // system clock
  input  wire eepc_ctl_t  nvm_control_reg, // control state seen
  input  wire logic [7:0] arr_rdata,       // read data
  output logic            arr_wr,          // array write strobe
  output logic            arr_rd,          // array read strobe
  output logic [15:0]     arr_addr,        // access address
  output logic [7:0]      arr_wdata,       // write data
  output logic            ctl_wr,          // control write strobe
  output eepc_ctl_t       ctl_wdata,       // control value
  output logic            div_wr,          // divider write strobe
  output logic [15:0]     div_wdata        // divider value
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam time DLY = 2ns;

  // idle bus at time zero
  initial begin
    {arr_wr, arr_rd, ctl_wr, div_wr} = 4'h0;
    arr_addr = 16'h0000;
    arr_wdata = 8'h00;
    ctl_wdata = CTL_RESET;
    div_wdata = 16'h0000;
  end

  // one strobe per call; released lines flip so stale values never look valid
  task automatic pulse(input int which, input logic [15:0] a, input logic [7:0] d,
                       input eepc_ctl_t c, input logic [15:0] v);
    @(posedge mclk);
    #DLY;
    arr_addr = a;
    arr_wdata = d;
    ctl_wdata = c;
    div_wdata = v;
    case (which)
      0: arr_wr = 1'b1;
      1: arr_rd = 1'b1;
      2: ctl_wr = 1'b1;
      default: div_wr = 1'b1;
    endcase
    @(posedge mclk);
    #DLY;
    {arr_wr, arr_rd, ctl_wr, div_wr} = 4'h0;
    arr_addr = ~arr_addr;
    arr_wdata = ~arr_wdata;
    ctl_wdata = ~ctl_wdata;
    div_wdata = ~div_wdata;
  endtask

  task automatic wr_arr(input logic [15:0] a, input logic [7:0] d);
    pulse(0, a, d, ctl_wdata, div_wdata);
  endtask

  // result is captured at the sampling edge's settle point
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    pulse(1, a, arr_wdata, ctl_wdata, div_wdata);
    d = arr_rdata;
  endtask

  task automatic wr_ctl(input eepc_ctl_t c);
    pulse(2, arr_addr, arr_wdata, c, div_wdata);
  endtask

  task automatic wr_div(input logic [15:0] v);
    pulse(3, arr_addr, arr_wdata, ctl_wdata, v);
  endtask

  // poll the control bit, never the array, while voltage is up
  task automatic wait_hv(output int cyc);
    cyc = 0;
    while (nvm_control_reg.hv_enable_bit === 1'b1 && cyc < 3000) begin
      @(posedge mclk);
      #DLY;
      cyc++;
    end
  endtask

  // full sequence; hold 0 selects automatic end, else manual wait in cycles
  task automatic run_op(input eepc_op_t op, input logic [15:0] a, input logic [7:0] d,
                        input int hold, output int cyc, output eepc_ctl_t mid);
    eepc_ctl_t c;
    c = CTL_RESET;
    c.bus_latch_bit = 1'b1;
    c.auto_mode = (hold == 0);
    {c.op_select_hi, c.op_select_lo} = op;
    wr_ctl(c);
    wr_arr(a, d);
    c.hv_enable_bit = 1'b1;
    wr_ctl(c);
    mid = nvm_control_reg;
    if (hold == 0) begin
      wait_hv(cyc);
    end else begin
      cyc = hold;
      repeat (hold) @(posedge mclk);
      wr_ctl(CTL_RESET);
      mid = nvm_control_reg;
    end
    wr_ctl(CTL_RESET);
  endtask
endmodule // eepc_cpu_model
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench
  import eepc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        crystal_clock = 1'b0;
  logic        timebase_clock_select = 1'b0;
  logic        factory_erase = 1'b1;
  logic        arr_wr, arr_rd, ctl_wr, div_wr, op_fail;
  logic [15:0] arr_addr, div_wdata, timebase_divider;
  logic [7:0]  arr_wdata, arr_rdata, v;
  eepc_ctl_t   ctl_wdata, nvm_control_reg, c, last_mid;
  eepc_acr_t   array_config_reg;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          last_cyc;

  always #10 mclk = ~mclk;
  // free-running reference at one third of the mclk rate, its rising edges on mclk rising edges
  always #30 crystal_clock = ~crystal_clock;

  eepc_ctrl eepc_ctrl_inst (.mclk(mclk), .reset(reset), .crystal_clock(crystal_clock),
    .timebase_clock_select(timebase_clock_select), .factory_erase(factory_erase), .arr_wr(arr_wr),
    .arr_rd(arr_rd), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .nvm_control_reg(nvm_control_reg), .div_wr(div_wr), .div_wdata(div_wdata),
    .timebase_divider(timebase_divider), .array_config_reg(array_config_reg), .op_fail(op_fail));

  eepc_cpu_model eepc_cpu_model_inst (.mclk(mclk), .nvm_control_reg(nvm_control_reg), .arr_rdata(arr_rdata),
    .arr_wr(arr_wr), .arr_rd(arr_rd), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .div_wr(div_wr), .div_wdata(div_wdata));

  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard: whole run needs well under 10k cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      $display("timeout after %0d cycles", cycles);
      report_and_stop;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    eepc_cpu_model_inst.rd(a, v);
    chk($sformatf("byte at %h", a), {8'h00, exp}, {8'h00, v});
  endtask

  task automatic do_op(input eepc_op_t op, input logic [15:0] a, input logic [7:0] d, input int hold,
                       input logic fail);
    eepc_cpu_model_inst.run_op(op, a, d, hold, last_cyc, last_mid);
    chk("op_fail", {15'h0000, fail}, {15'h0000, op_fail});
    chk("control after op", 16'h0000, {9'h000, nvm_control_reg});
  endtask

  task automatic do_reset;
    @(posedge mclk);
    #2 reset = 1'b1;
    repeat (10) @(posedge mclk);
    #2 reset = 1'b0;
    repeat (2) @(posedge mclk);
    #2;
  endtask

  initial begin
    // cells erased while the first reset is held, so the reload sees known bytes
    @(posedge mclk);
    #2 factory_erase = 1'b0;
    do_reset();
    chk("config", 16'h00ff, {8'h00, array_config_reg});
    chk("divider", 16'hffff, timebase_divider);
    chk("control", 16'h0000, {9'h000, nvm_control_reg});
    rd_chk(ARR_BASE, ERASED);
    rd_chk(ARR_LAST, ERASED);
    eepc_cpu_model_inst.wr_div(16'h0001);
    chk("divider", 16'h0001, timebase_divider);
    $display("test reset_load finished");
    // open all blocks, applied by reading the option byte
    do_op(OP_BYTE_PGM, NVCFG_ADDR, 8'hf0, 0, 1'b0);
    rd_chk(NVCFG_ADDR, 8'hf0);
    chk("config", 16'h00f0, {8'h00, array_config_reg});
    do_op(OP_BYTE_PGM, 16'h0800, 8'hfe, 0, 1'b0);
    chk("auto length", 16'h0001, {15'h0, last_cyc >= int'(AUTO_TICKS) && last_cyc < int'(NOM_TICKS)});
    do_op(OP_BYTE_PGM, 16'h0800, 8'hfd, 0, 1'b0);
    rd_chk(16'h0800, 8'hfc);
    c = CTL_RESET;
    c.array_power_down = 1'b1;
    eepc_cpu_model_inst.wr_ctl(c);
    rd_chk(16'h0800, 8'hff);
    eepc_cpu_model_inst.wr_ctl(CTL_RESET);
    $display("test bit_program finished");
    // latch rules: no target yet, invalid target, read retargets
    c = CTL_RESET;
    c.bus_latch_bit = 1'b1;
    eepc_cpu_model_inst.wr_ctl(c);
    c.hv_enable_bit = 1'b1;
    eepc_cpu_model_inst.wr_ctl(c);
    chk("control", 16'h0004, {9'h000, nvm_control_reg});
    eepc_cpu_model_inst.wr_arr(16'h0a00, 8'h00);
    eepc_cpu_model_inst.wr_ctl(c);
    chk("control", 16'h0004, {9'h000, nvm_control_reg});
    eepc_cpu_model_inst.wr_arr(16'h0801, 8'h0f);
    rd_chk(16'h0802, 8'h0f);
    c.auto_mode = 1'b1;
    eepc_cpu_model_inst.wr_ctl(c);
    eepc_cpu_model_inst.wait_hv(last_cyc);
    eepc_cpu_model_inst.wr_ctl(CTL_RESET);
    rd_chk(16'h0801, 8'hff);
    rd_chk(16'h0802, 8'h0f);
    $display("test latch_rules finished");
    do_op(OP_BYTE_PGM, 16'h0803, 8'h3c, 270, 1'b0);
    chk("latch kept", 16'h0004, {9'h000, last_mid});
    rd_chk(16'h0803, 8'h3c);
    do_op(OP_BYTE_PGM, 16'h0804, 8'h00, 10, 1'b1);
    rd_chk(16'h0804, 8'hff);
    $display("test manual_mode finished");
    do_op(OP_BYTE_PGM, 16'h0900, 8'h55, 0, 1'b0);
    do_op(OP_BYTE_ERS, 16'h0803, 8'h00, 0, 1'b0);
    rd_chk(16'h0803, 8'hff);
    rd_chk(16'h0802, 8'h0f);
    do_op(OP_BLOCK_ERS, 16'h0801, 8'h00, 0, 1'b0);
    rd_chk(16'h0802, 8'hff);
    rd_chk(16'h0900, 8'h55);
    do_op(OP_BULK_ERS, 16'h0900, 8'h00, 0, 1'b0);
    rd_chk(16'h0900, 8'hff);
    do_op(OP_BYTE_PGM, 16'h08f0, 8'ha5, 0, 1'b0);
    $display("test erase_modes finished");
    do_op(OP_BYTE_ERS, NVCFG_ADDR, 8'h00, 0, 1'b0);
    rd_chk(NVCFG_ADDR, 8'hff);
    chk("config", 16'h00ff, {8'h00, array_config_reg});
    do_op(OP_BYTE_PGM, 16'h0880, 8'h00, 0, 1'b1);
    chk("hv cycles", 16'h0000, last_cyc[15:0]);
    do_op(OP_BYTE_PGM, NVCFG_ADDR, 8'hf2, 0, 1'b0);
    rd_chk(NVCFG_ADDR, 8'hf2);
    do_op(OP_BYTE_PGM, 16'h0880, 8'h00, 0, 1'b1);
    rd_chk(16'h0880, 8'hff);
    do_op(OP_BYTE_PGM, 16'h0900, 8'h11, 0, 1'b0);
    rd_chk(16'h0900, 8'h11);
    do_op(OP_BYTE_PGM, NVCFG_ADDR, 8'hed, 0, 1'b0);
    do_op(OP_BYTE_PGM, NVDIVH_ADDR, 8'h00, 0, 1'b0);
    do_op(OP_BYTE_PGM, NVDIVL_ADDR, 8'h01, 0, 1'b0);
    $display("test block_protect finished");
    // armed security and divider lock, timed from the crystal reference
    timebase_clock_select = 1'b1;
    do_reset();
    chk("config", 16'h00e0, {8'h00, array_config_reg});
    chk("divider", 16'h0001, timebase_divider);
    eepc_cpu_model_inst.wr_div(16'hffff);
    chk("divider", 16'h0001, timebase_divider);
    rd_chk(16'h08f0, 8'ha5);
    do_op(OP_BYTE_PGM, 16'h08f0, 8'h00, 0, 1'b1);
    rd_chk(16'h08f0, 8'ha5);
    do_op(OP_BLOCK_ERS, 16'h0900, 8'h00, 0, 1'b1);
    do_op(OP_BULK_ERS, 16'h0900, 8'h00, 0, 1'b1);
    do_op(OP_BYTE_PGM, NVCFG_ADDR, 8'h00, 0, 1'b1);
    do_op(OP_BYTE_PGM, NVDIVL_ADDR, 8'h00, 0, 1'b1);
    do_op(OP_BYTE_ERS, 16'h0900, 8'h00, 0, 1'b0);
    rd_chk(16'h0900, 8'hff);
    $display("test security finished");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire

// [verilog/eepc_ctrl.sv]
`default_nettype none
module eepc_ctrl
  import eepc_pkg::*;
(
  input  wire logic        mclk,                  // system clock
  input  wire logic        reset,                 // async, high
  input  wire logic        crystal_clock,         // timebase reference pin
  input  wire logic        timebase_clock_select, // 1 = crystal clock
  input  wire logic        factory_erase,         // sets all cells to 0xff
  input  wire logic        arr_wr,                // array write strobe
  input  wire logic        arr_rd,                // array read strobe
  input  wire logic [15:0] arr_addr,              // access address
  input  wire logic [7:0]  arr_wdata,             // write data
  output logic      [7:0]  arr_rdata,             // read data, next cycle
  input  wire logic        ctl_wr,                // control write strobe
  input  wire eepc_ctl_t   ctl_wdata,             // control write value
  output eepc_ctl_t        nvm_control_reg,       // control bits
  input  wire logic        div_wr,                // divider write strobe
  input  wire logic [15:0] div_wdata,             // divider write value
  output logic      [15:0] timebase_divider,      // working divider
  output eepc_acr_t        array_config_reg,      // working config
  output logic             op_fail                // last cycle refused or not committed
);
  typedef struct packed {
    eepc_ctl_t   ctl;
    eepc_acr_t   acr;
    logic [15:0] div;
    logic [15:0] lat_addr;
    logic [7:0]  lat_data;
    logic        addr_valid;
    logic [9:0]  ticks;
    logic        disturbed;
    logic        op_fail;
    logic [7:0]  rdata;
    logic        load_pend;
    logic        div_locked;
  } eepc_st_t;

  typedef struct packed {
    logic [ARR_BYTES-1:0][7:0] mem;
    logic [7:0]                cfg;
    logic [7:0]                divh;
    logic [7:0]                divl;
  } eepc_nv_t;

  eepc_st_t  st_r, st_nxt;
  eepc_nv_t  nv_r, nv_nxt;
  logic      tick;
  logic      start_hv;
  logic      end_hv;
  logic      commit;
  logic      target_ok;
  logic      sec_hit;
  logic      ctl_ok;
  logic      rd_valid;
  logic      wr_valid;
  logic [8:0] t_idx;
  logic [7:0] pgm_val;
  eepc_op_t  op;

  function automatic logic in_arr(input logic [15:0] a);
    return (a >= ARR_BASE) && (a <= ARR_LAST); // [R01]
  endfunction

  function automatic logic is_valid(input logic [15:0] a);
    return in_arr(a) || a == NVCFG_ADDR || a == NVDIVH_ADDR || a == NVDIVL_ADDR;
  endfunction

  // whether the latched target may be changed by op
  function automatic logic may_touch(input eepc_op_t o, input logic [15:0] a,
                                     input eepc_acr_t c, input logic div_open);
    logic secured;
    logic wide;
    secured = ~c.region_security_bit;
    wide    = (o == OP_BLOCK_ERS) || (o == OP_BULK_ERS);
    if (in_arr(a)) begin
      return !c.block_protect_bits[a[BLK_MSB:BLK_LSB]]           // [R07] [R23]
             && !(secured && a >= SEC_FIRST && a <= SEC_LAST)  // [R05]
             && !(secured && wide);                            // [R06]
    end else if (a == NVCFG_ADDR) begin
      return !secured && !wide;                                // [R06]
    end else begin
      return div_open && !wide;                                // [R09]
    end
  endfunction

  eepc_timebase u_timebase (
    .mclk                  (mclk),
    .reset                 (reset),
    .crystal_clock         (crystal_clock),
    .timebase_clock_select (timebase_clock_select),
    .timebase_divider      (st_r.div),
    .restart               (start_hv),
    .tick                  (tick)
  );

  // decode of the pending operation and its permission
  always_comb begin
    op        = eepc_op_t'({st_r.ctl.op_select_hi, st_r.ctl.op_select_lo});
    t_idx     = st_r.lat_addr[IDX_MSB:0];
    target_ok = may_touch(op, st_r.lat_addr, st_r.acr, !st_r.div_locked);
    sec_hit   = ~st_r.acr.region_security_bit && st_r.lat_addr >= SEC_FIRST
                && st_r.lat_addr <= SEC_LAST;
    pgm_val   = nv_r.mem[t_idx] & st_r.lat_data;
    rd_valid  = arr_rd && is_valid(arr_addr);
    wr_valid  = arr_wr && is_valid(arr_addr);
    // control writes are dropped while latched without a valid target
    ctl_ok    = ctl_wr && !(st_r.ctl.bus_latch_bit && !st_r.addr_valid); // [R16]
    start_hv  = ctl_ok && ctl_wdata.hv_enable_bit && !st_r.ctl.hv_enable_bit
                && st_r.ctl.bus_latch_bit && st_r.addr_valid            // [R18]
                && target_ok && !st_r.ctl.array_power_down;             // [R27] [R25]
    end_hv    = st_r.ctl.hv_enable_bit
                && ((st_r.ctl.auto_mode && st_r.ticks >= AUTO_TICKS)    // [R13]
                    || (ctl_ok && !ctl_wdata.hv_enable_bit));
    // a short or disturbed cycle leaves the cells untouched
    commit    = end_hv && target_ok && !st_r.disturbed                  // [R19] [R22]
                && st_r.ticks >= AUTO_TICKS;
  end

  // working registers, latch and high-voltage sequencing
  always_comb begin
    st_nxt = st_r;
    if (st_r.load_pend) begin
      st_nxt.load_pend = 1'b0;
      st_nxt.acr       = nv_r.cfg;             // [R02]
      st_nxt.div       = {nv_r.divh, nv_r.divl}; // [R02] [R09]
      // lock arms only from the reloaded copy, so software writes of bit 15 stay harmless
      st_nxt.div_locked = ~st_nxt.div[DIV_SEC_BIT]; // [R09]
    end
    if (div_wr && !st_r.div_locked && !st_r.load_pend) begin
      st_nxt.div = div_wdata; // [R09]
    end
    if (st_r.ctl.hv_enable_bit && tick && st_r.ticks != TICKS_MAX) begin
      st_nxt.ticks = st_r.ticks + 10'h001; // [R03]
    end
    if (ctl_ok) begin
      st_nxt.ctl.spare            = ctl_wdata.spare;
      st_nxt.ctl.array_power_down = ctl_wdata.array_power_down;
      st_nxt.ctl.op_select_hi     = ctl_wdata.op_select_hi;
      st_nxt.ctl.op_select_lo     = ctl_wdata.op_select_lo;
      st_nxt.ctl.auto_mode        = ctl_wdata.auto_mode;
      // latch survives any write made while voltage is on
      st_nxt.ctl.bus_latch_bit    = ctl_wdata.bus_latch_bit
                                    | st_r.ctl.hv_enable_bit; // [R20] [R24]
      if (!st_nxt.ctl.bus_latch_bit) begin
        st_nxt.addr_valid = 1'b0;
      end
      if (ctl_wdata.hv_enable_bit && !st_r.ctl.hv_enable_bit) begin
        st_nxt.op_fail = !start_hv; // [R18] [R27]
      end
    end
    if (start_hv) begin
      st_nxt.ctl.hv_enable_bit = 1'b1;
      st_nxt.ticks             = 10'h000;
      st_nxt.disturbed         = 1'b0;
    end
    if (end_hv) begin
      st_nxt.ctl.hv_enable_bit = 1'b0; // [R13] [R20]
      st_nxt.op_fail           = !commit;
    end
    // array port: read path and latch capture
    if (arr_rd) begin
      if (st_r.ctl.hv_enable_bit) begin
        st_nxt.disturbed = 1'b1; // [R19]
        st_nxt.rdata     = ERASED;
      end else if (st_r.ctl.bus_latch_bit && rd_valid) begin
        st_nxt.rdata      = st_r.lat_data; // [R17]
        st_nxt.lat_addr   = arr_addr;      // [R17]
        st_nxt.addr_valid = 1'b1;
      end else if (st_r.ctl.array_power_down) begin
        st_nxt.rdata = ERASED; // contents unusable while powered down
      end else if (in_arr(arr_addr)) begin
        st_nxt.rdata = nv_r.mem[arr_addr[IDX_MSB:0]];
      end else if (arr_addr == NVCFG_ADDR) begin
        st_nxt.rdata = nv_r.cfg;
        st_nxt.acr.block_protect_bits = nv_r.cfg[3:0]; // [R08]
      end else if (arr_addr == NVDIVH_ADDR) begin
        st_nxt.rdata = nv_r.divh;
      end else if (arr_addr == NVDIVL_ADDR) begin
        st_nxt.rdata = nv_r.divl;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
    if (wr_valid && st_r.ctl.bus_latch_bit && !st_r.ctl.hv_enable_bit) begin
      st_nxt.lat_addr   = arr_addr;  // [R16] [R17]
      st_nxt.lat_data   = arr_wdata;
      st_nxt.addr_valid = 1'b1;
    end
  end

  // cell updates on factory erase or when a cycle completes
  always_comb begin
    nv_nxt = nv_r;
    if (factory_erase) begin
      nv_nxt = '1; // [R10]
    end else if (commit) begin
      if (in_arr(st_r.lat_addr)) begin
        unique case (op)
          OP_BYTE_PGM: nv_nxt.mem[t_idx] = pgm_val; // [R10]
          OP_BYTE_ERS: nv_nxt.mem[t_idx] = ERASED;  // [R11]
          OP_BLOCK_ERS: begin
            for (int i = 0; i < ARR_BYTES; i++) begin
              if (9'(i) >> BLK_LSB == t_idx >> BLK_LSB) begin
                nv_nxt.mem[i] = ERASED; // [R11]
              end
            end
          end
          OP_BULK_ERS: begin
            for (int i = 0; i < ARR_BYTES; i++) begin
              if (!st_r.acr.block_protect_bits[2'(9'(i) >> BLK_LSB)]) begin
                nv_nxt.mem[i] = ERASED; // [R11] [R22]
              end
            end
          end
        endcase
      end else begin
        // option bytes take byte program or byte erase only
        unique case (st_r.lat_addr)
          NVCFG_ADDR: nv_nxt.cfg = op[0] ? ERASED : (nv_r.cfg & st_r.lat_data);
          NVDIVH_ADDR: nv_nxt.divh = op[0] ? ERASED : (nv_r.divh & st_r.lat_data);
          default: nv_nxt.divl = op[0] ? ERASED : (nv_r.divl & st_r.lat_data);
        endcase
      end
    end
  end

  // volatile state; reset requests the option reload
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r           <= '0;
      st_r.ctl       <= CTL_RESET; // [R24]
      st_r.load_pend <= 1'b1;      // [R02]
    end else begin
      st_r <= st_nxt;
    end
  end

  // nonvolatile cells keep their contents through reset
  always_ff @(posedge mclk) begin
    nv_r <= nv_nxt;
  end

  assign arr_rdata        = st_r.rdata;
  assign nvm_control_reg  = st_r.ctl;
  assign timebase_divider = st_r.div;
  assign array_config_reg = st_r.acr;
  assign op_fail          = st_r.op_fail;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_hv_on;
    $rose(st_r.ctl.hv_enable_bit);
  endsequence

  sequence s_auto_due;
    st_r.ctl.hv_enable_bit && st_r.ctl.auto_mode && st_r.ticks >= AUTO_TICKS;
  endsequence

  chk_hv_needs_latch: assert property ( // [R18]
    s_hv_on |-> $past(st_r.ctl.bus_latch_bit) && $past(st_r.addr_valid))
    else $error("enable set without latch or target");

  chk_latch_under_hv: assert property ( // [R24]
    st_r.ctl.hv_enable_bit |-> st_r.ctl.bus_latch_bit)
    else $error("latch dropped while voltage on");

  chk_both_clear: assert property ( // [R20]
    ctl_wr && !ctl_wdata.hv_enable_bit && !ctl_wdata.bus_latch_bit
    && st_r.ctl.hv_enable_bit |=> st_r.ctl.bus_latch_bit && !st_r.ctl.hv_enable_bit)
    else $error("single write cleared the latch");

  chk_auto_end: assert property ( // [R13]
    s_auto_due |=> !st_r.ctl.hv_enable_bit)
    else $error("auto cycle did not end");

  chk_auto_short: assert property ( // [R21]
    st_r.ctl.hv_enable_bit && st_r.ctl.auto_mode |-> st_r.ticks < NOM_TICKS)
    else $error("auto cycle reached nominal time");

  chk_pgm_value: assert property ( // [R10]
    commit && op == OP_BYTE_PGM && in_arr(st_r.lat_addr)
    |=> nv_r.mem[$past(t_idx)] == $past(pgm_val))
    else $error("program did not store old and data");

  chk_secured_region: assert property ( // [R05]
    sec_hit && !factory_erase |=> nv_r.mem[$past(t_idx)] == $past(nv_r.mem[t_idx]))
    else $error("secured byte changed");

  chk_option_reload: assert property ( // [R02]
    st_r.load_pend |=> array_config_reg == $past(nv_r.cfg))
    else $error("config copy not loaded at reset");

  chk_div_locked: assert property ( // [R09]
    st_r.div_locked && !st_r.load_pend |=> st_r.div == $past(st_r.div))
    else $error("secured divider changed");

  chk_latch_capture: assert property ( // [R16]
    wr_valid && st_r.ctl.bus_latch_bit && !st_r.ctl.hv_enable_bit
    |=> st_r.lat_addr == $past(arr_addr) && st_r.addr_valid)
    else $error("valid write not captured");
endmodule : eepc_ctrl
`default_nettype wire

// [verilog/eepc_timebase.sv]
`default_nettype none
module eepc_timebase
  import eepc_pkg::*;
(
  input  wire logic        mclk,                  // system clock
  input  wire logic        reset,                 // async, high
  input  wire logic        crystal_clock,         // pin, asynchronous
  input  wire logic        timebase_clock_select, // 1 = crystal clock
  input  wire logic [15:0] timebase_divider,      // divide ratio
  input  wire logic        restart,               // zero the count
  output logic             tick                   // one-cycle pulse
);
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic [15:0] count;
    logic        tick;
  } eepc_tb_st_t;

  eepc_tb_st_t st_r, st_nxt;
  logic        ref_en;

  // crystal edges counted after a two-flop synchroniser
  always_comb begin
    st_nxt       = st_r;
    st_nxt.s1    = crystal_clock;
    st_nxt.s2    = st_r.s1;
    st_nxt.s3    = st_r.s2;
    st_nxt.tick  = 1'b0;
    ref_en       = timebase_clock_select ? (st_r.s2 & ~st_r.s3) : 1'b1;
    if (restart || timebase_divider == 16'h0000) begin
      st_nxt.count = 16'h0000; // zero ratio stalls the timebase
    end else if (ref_en) begin
      if (st_r.count >= timebase_divider - 16'h0001) begin
        st_nxt.count = 16'h0000; // [R26]
        st_nxt.tick  = 1'b1;     // [R03]
      end else begin
        st_nxt.count = st_r.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule : eepc_timebase
`default_nettype wire
